// *** src/dram_board_cfg.svh ***
// Purpose: named constants of the dram board decode and refresh logic
// Assumes: 40 MHz system clock, period 25 ns
// Notes:   times in ns, cycle counts derived from them
`ifndef DRAM_BOARD_CFG_SVH
`define DRAM_BOARD_CFG_SVH

// ----------------------------------------
// geometry
// ----------------------------------------
`define CLK_PERIOD_NS   25
`define WORD_BITS       8
`define ADDR_BITS       16
`define BLOCK_ADDR_BITS 13
`define BLOCK_COUNT     4
`define REGION_BITS     3
`define STORE_ADDR_BITS 15
`define STORE_WORDS     32768
`define REDUCED_BLOCKS  2

// ----------------------------------------
// timing
// ----------------------------------------
`define REFRESH_NS        760
`define REFRESH_CYC       (`REFRESH_NS / `CLK_PERIOD_NS)
`define ACCESS_NS         400
`define ACCESS_CYC        (`ACCESS_NS / `CLK_PERIOD_NS)
`define REFRESH_PERIOD_NS 15625
`define REFRESH_PERIOD_CYC (`REFRESH_PERIOD_NS / `CLK_PERIOD_NS)
`define TIMER_BITS        10

`endif

// *** src/dram_board_decode_refresh.sv ***
// Purpose: decode, sequencing and self-timed refresh of a 32K x 8 dram board
// Assumes: bus strobes and address synchronous to clock; reset_n is system init
// Notes:   bus address and data are active low as on the backplane
// Contract
// - stores up to 32K words of 8 bits, one whole word per cycle.
// - board times its own refresh, independent of the bus master.
// - access arriving during refresh waits for it, up to 750 ns extra.
// - storage sits in a 64K space as 8K blocks on 8K boundaries.
// - eight region selects; each block answers only inside its tied region.
// - reduced 16K build uses only the first two blocks.
`timescale 1ns/1ps
`include "dram_board_cfg.svh"

module dram_board_decode_refresh (
	input  wire logic                          clock,
	input  wire logic                          reset_n,
	input  wire logic                          mem_read_cmd_n,
	input  wire logic                          mem_write_cmd_n,
	input  wire logic [`ADDR_BITS-1:0]         bus_addr_n,
	input  wire logic [`WORD_BITS-1:0]         bus_data_n_in,
	output logic      [`WORD_BITS-1:0]         bus_data_n_out,
	output logic                               bus_data_oe,
	output logic                               transfer_ack_n,
	input  wire dram_board_pkg::region_t [`BLOCK_COUNT-1:0] block_map_header,
	input  wire logic                          reduced_build
);
	import dram_board_pkg::*;

	localparam int REF_CYC_I = `REFRESH_CYC;
	localparam int ACC_CYC_I = `ACCESS_CYC;

	state_t                       state;
	logic [`TIMER_BITS-1:0]       refresh_timer;
	logic                         refresh_due;
	logic [`TIMER_BITS-1:0]       seq_count;
	logic [`WORD_BITS-1:0]        store [0:`STORE_WORDS-1];
	logic [`STORE_ADDR_BITS-1:0]  word_index;
	logic                         is_write;
	logic [`BLOCK_COUNT-1:0]      block_hit;
	logic [`BLOCK_COUNT-1:0]      block_fitted;
	region_t                      region;
	logic [1:0]                   hit_block;
	logic                         selected;
	logic                         cmd_active;
	logic [`ADDR_BITS-1:0]        addr;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	// bus address lines are active low, so flip them once here
	assign addr       = ~bus_addr_n;
	assign region     = addr[`ADDR_BITS-1:`BLOCK_ADDR_BITS];
	assign cmd_active = !mem_read_cmd_n || !mem_write_cmd_n;

	// one comparator per block against its header strap
	genvar b;
	generate
		for (b = 0; b < `BLOCK_COUNT; b++) begin : g_block
			assign block_fitted[b] = (b < `REDUCED_BLOCKS) || !reduced_build;
			assign block_hit[b]    = block_fitted[b] &&
				(block_map_header[b] == region);
		end
	endgenerate

	// lowest block wins if the straps overlap; overlap is a config error
	always_comb begin
		hit_block = 2'h0;
		if (block_hit[0]) begin
			hit_block = 2'h0;
		end else if (block_hit[1]) begin
			hit_block = 2'h1;
		end else if (block_hit[2]) begin
			hit_block = 2'h2;
		end else if (block_hit[3]) begin
			hit_block = 2'h3;
		end
	end
	assign selected = |block_hit;

	// ----------------------------------------
	// refresh timer
	// ----------------------------------------
	// free running, not tied to bus activity; a due refresh waits for idle
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			refresh_timer <= '0;
			refresh_due   <= 1'b0;
		end else begin
			if (refresh_timer == `TIMER_BITS'(`REFRESH_PERIOD_CYC - 1)) begin
				refresh_timer <= '0;
				refresh_due   <= 1'b1;
			end else begin
				refresh_timer <= refresh_timer + `TIMER_BITS'(1);
				if (state == st_refresh) begin
					refresh_due <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	// refresh has priority in idle so a late access simply waits behind it
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state          <= st_idle;
			seq_count      <= '0;
			word_index     <= '0;
			is_write       <= 1'b0;
			transfer_ack_n <= 1'b1;
		end else begin
			case (state)
				st_idle: begin
					seq_count <= '0;
					if (refresh_due) begin
						state <= st_refresh;
					end else if (cmd_active && selected) begin
						state      <= st_access;
						word_index <= {hit_block, addr[`BLOCK_ADDR_BITS-1:0]};
						is_write   <= !mem_write_cmd_n;
					end
				end
				st_refresh: begin
					// the bus access, if any, is stretched by the rest of this wait
					if (seq_count == `TIMER_BITS'(`REFRESH_CYC - 1)) begin
						seq_count <= '0;
						// a waiting access starts at once; an idle hop would overrun the stretch
						if (cmd_active && selected) begin
							state      <= st_access;
							word_index <= {hit_block, addr[`BLOCK_ADDR_BITS-1:0]};
							is_write   <= !mem_write_cmd_n;
						end else begin
							state <= st_idle;
						end
					end else begin
						seq_count <= seq_count + `TIMER_BITS'(1);
					end
				end
				st_access: begin
					if (seq_count == `TIMER_BITS'(`ACCESS_CYC - 1)) begin
						state          <= st_ack;
						transfer_ack_n <= 1'b0;
					end else begin
						seq_count <= seq_count + `TIMER_BITS'(1);
					end
				end
				st_ack: begin
					if (!cmd_active) begin
						state          <= st_idle;
						transfer_ack_n <= 1'b1;
					end
				end
				default: begin
					state <= st_idle;
				end
			endcase
		end
	end

	// ----------------------------------------
	// storage and data bus
	// ----------------------------------------
	// write data is taken at the end of the access time, then acked
	always_ff @(posedge clock) begin
		if (state == st_access && seq_count == `TIMER_BITS'(`ACCESS_CYC - 1)
			&& is_write) begin
			store[word_index] <= ~bus_data_n_in;
		end
	end

	// read data is driven with the ack and dropped as the strobe ends
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			bus_data_n_out <= '1;
			bus_data_oe    <= 1'b0;
		end else if (state == st_access && seq_count == `TIMER_BITS'(`ACCESS_CYC - 1)
			&& !is_write) begin
			bus_data_n_out <= ~store[word_index];
			bus_data_oe    <= 1'b1;
		end else if (state == st_ack && !cmd_active) begin
			bus_data_oe    <= 1'b0;
			bus_data_n_out <= '1;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_ack_after_access;
		@(posedge clock) disable iff (!reset_n)
		$fell(transfer_ack_n) |-> $past(state == st_access, 1) &&
			$past(seq_count, 1) == `TIMER_BITS'(ACC_CYC_I - 1);
	endproperty
	a_ack_after_access: assert property (p_ack_after_access)
		else $error("ack without a completed access");

	property p_ack_release;
		@(posedge clock) disable iff (!reset_n)
		(!transfer_ack_n && mem_read_cmd_n && mem_write_cmd_n) |=> transfer_ack_n;
	endproperty
	a_ack_release: assert property (p_ack_release)
		else $error("ack held after strobe ended");

	property p_init_clears;
		@(posedge clock) !reset_n |=> (state == st_idle) && transfer_ack_n && !bus_data_oe;
	endproperty
	a_init_clears: assert property (p_init_clears)
		else $error("init did not clear sequencer");

	property p_refresh_length;
		@(posedge clock) disable iff (!reset_n)
		$rose(state == st_refresh) |-> (state == st_refresh) [*8] ##(REF_CYC_I - 7)
			(state != st_refresh);
	endproperty
	a_refresh_length: assert property (p_refresh_length)
		else $error("refresh length wrong");

	property p_refresh_self_timed;
		@(posedge clock) disable iff (!reset_n)
		$rose(refresh_due) |-> $past(refresh_timer) ==
			`TIMER_BITS'(`REFRESH_PERIOD_CYC - 1);
	endproperty
	a_refresh_self_timed: assert property (p_refresh_self_timed)
		else $error("refresh request not from own timer");

	property p_refresh_blocks_ack;
		@(posedge clock) disable iff (!reset_n)
		(state == st_refresh) |-> transfer_ack_n;
	endproperty
	a_refresh_blocks_ack: assert property (p_refresh_blocks_ack)
		else $error("ack during refresh");

	property p_reduced_blocks;
		@(posedge clock) disable iff (!reset_n)
		reduced_build |-> block_hit[3:2] == 2'h0;
	endproperty
	a_reduced_blocks: assert property (p_reduced_blocks)
		else $error("unfitted block answered");

	property p_unselected_ignored;
		@(posedge clock) disable iff (!reset_n)
		(state == st_idle && !refresh_due && !selected) |=> state != st_access;
	endproperty
	a_unselected_ignored: assert property (p_unselected_ignored)
		else $error("access outside mapped regions");

	property p_region_match;
		@(posedge clock) disable iff (!reset_n)
		(state == st_idle && !refresh_due && cmd_active && selected) |=>
			block_map_header[word_index[`STORE_ADDR_BITS-1:`BLOCK_ADDR_BITS]] ==
			$past(region);
	endproperty
	a_region_match: assert property (p_region_match)
		else $error("word routed to wrong block");

	property p_read_drives;
		@(posedge clock) disable iff (!reset_n)
		(!transfer_ack_n && !is_write) |-> bus_data_oe;
	endproperty
	a_read_drives: assert property (p_read_drives)
		else $error("read acked without data");

	c_read: cover property (@(posedge clock) disable iff (!reset_n)
		$fell(transfer_ack_n) && !is_write);
	c_write: cover property (@(posedge clock) disable iff (!reset_n)
		$fell(transfer_ack_n) && is_write);
	c_stretched: cover property (@(posedge clock) disable iff (!reset_n)
		(state == st_refresh && cmd_active) ##[1:40] !transfer_ack_n);
	c_reduced: cover property (@(posedge clock) disable iff (!reset_n)
		reduced_build && !transfer_ack_n);
endmodule

// *** src/dram_board_pkg.sv ***
// Purpose: shared types of the dram board decode and refresh logic
// Assumes: nothing beyond the cfg header
// Notes:   one-hot sequencer states
package dram_board_pkg;
	typedef logic [2:0] region_t;
	typedef enum logic [3:0] {
		st_idle    = 4'h1,
		st_refresh = 4'h2,
		st_access  = 4'h4,
		st_ack     = 4'h8
	} state_t;
endpackage

// *** tb/bus_master_model.sv ***
// Purpose: bus master model that runs read and write cycles on the board
// Assumes: inputs change on the falling edge only
// Notes:   released lines show the inverse of their last value
`timescale 1ns/1ps
`include "dram_board_cfg.svh"

module bus_master_model (
	input  wire logic                  clock,
	output logic                       mem_read_cmd_n,
	output logic                       mem_write_cmd_n,
	output logic [`ADDR_BITS-1:0]      bus_addr_n,
	output logic [`WORD_BITS-1:0]      bus_data_n_in,
	input  wire logic                  transfer_ack_n,
	input  wire logic                  bus_data_oe,
	input  wire logic [`WORD_BITS-1:0] bus_data_n_out
);
	// ----------------------------------------
	// idle bus
	// ----------------------------------------
	initial begin
		mem_read_cmd_n = 1'b1;
		mem_write_cmd_n = 1'b1;
		bus_addr_n = 16'hFFFF;
		bus_data_n_in = 8'hFF;
	end

	// one whole cycle; length is never assumed, the ack decides it
	task automatic access(input logic wr, input logic [`ADDR_BITS-1:0] a,
		input logic [`WORD_BITS-1:0] d, output logic [`WORD_BITS-1:0] q,
		output logic ok, output logic oe_seen, output int lat, output int rel);
		lat = 0;
		rel = 0;
		@(negedge clock);
		bus_addr_n = ~a;
		bus_data_n_in = ~d;
		if (wr)
			mem_write_cmd_n = 1'b0;
		else
			mem_read_cmd_n = 1'b0;
		while (transfer_ack_n !== 1'b0 && lat < 100) begin
			@(negedge clock);
			lat++;
		end
		ok = (transfer_ack_n === 1'b0);
		oe_seen = bus_data_oe;
		q = ~bus_data_n_out;
		mem_read_cmd_n = 1'b1;
		mem_write_cmd_n = 1'b1;
		// flipped lines so a stale address or word cannot pass for a held one
		bus_addr_n = a;
		bus_data_n_in = d;
		while (transfer_ack_n !== 1'b1 && rel < 100) begin
			@(negedge clock);
			rel++;
		end
		@(negedge clock);
	endtask
endmodule

// *** tb/dram_board_decode_refresh_test.sv ***
// Purpose: self-checking bench of the dram board decode and refresh logic
// Assumes: 40 MHz clock, bus master model as the far side
// Notes:   expected words follow from the block map that the bench sets
`timescale 1ns/1ps
`include "dram_board_cfg.svh"

module dram_board_decode_refresh_test;
	import dram_board_pkg::*;
	logic                   clock = 1'b0;
	logic                   reset_n = 1'b0;
	logic                   reduced_build = 1'b0;
	logic                   rd_n, wr_n, ack_n, oe;
	logic [`ADDR_BITS-1:0]  addr_n;
	logic [`WORD_BITS-1:0]  din_n, dout_n, q;
	region_t [3:0]          block_map_header = {3'h7, 3'h5, 3'h3, 3'h1};
	int                     errors = 0;
	int                     n_compared = 0;
	int                     lat, worst;

	always #12.5 clock = ~clock;

	dram_board_decode_refresh DUT (.clock(clock), .reset_n(reset_n),
		.mem_read_cmd_n(rd_n), .mem_write_cmd_n(wr_n), .bus_addr_n(addr_n),
		.bus_data_n_in(din_n), .bus_data_n_out(dout_n), .bus_data_oe(oe),
		.transfer_ack_n(ack_n), .block_map_header(block_map_header),
		.reduced_build(reduced_build));
	bus_master_model M (.clock(clock), .mem_read_cmd_n(rd_n), .mem_write_cmd_n(wr_n),
		.bus_addr_n(addr_n), .bus_data_n_in(din_n), .transfer_ack_n(ack_n),
		.bus_data_oe(oe), .bus_data_n_out(dout_n));

	// ----------------------------------------
	// reporting
	// ----------------------------------------
	task automatic end_of_test();
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic check_range(input int got, input int lo, input int hi, input string m);
		check_byte(8'(got >= lo && got <= hi), 8'h01, m);
	endtask

	// one cycle; a missing ack where one is due ends the run at once
	task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
		input logic exp_ack);
		logic ok, oe_seen;
		int rel;
		M.access(wr, a, d, q, ok, oe_seen, lat, rel);
		check_byte({7'h00, ok}, {7'h00, exp_ack}, "ack presence");
		if (ok === 1'b1) begin
			check_byte({7'h00, oe_seen}, {7'h00, ~wr}, "drive at ack");
			check_range(rel, 0, 2, "ack release");
		end
		if (exp_ack && ok !== 1'b1)
			end_of_test();
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		check_byte({6'h00, ack_n, oe}, 8'h02, "reset ack and drive");
		check_byte(dout_n, 8'hFF, "reset data lines");
	endtask

	// first and last word of every non-adjacent region, then holes
	task automatic t_map();
		for (int b = 0; b < 4; b++) begin
			acc(1'b1, {3'(2 * b + 1), 13'h0000}, {4'h5, 4'(b)}, 1'b1);
			acc(1'b1, {3'(2 * b + 1), 13'h1FFF}, {4'hC, 4'(b)}, 1'b1);
		end
		for (int b = 0; b < 4; b++) begin
			acc(1'b0, {3'(2 * b + 1), 13'h0000}, 8'h00, 1'b1);
			check_byte(q, {4'h5, 4'(b)}, "region base word");
			acc(1'b0, {3'(2 * b + 1), 13'h1FFF}, 8'h00, 1'b1);
			check_byte(q, {4'hC, 4'(b)}, "region top word");
			acc(1'b0, {3'(2 * b), 13'h1000}, 8'h00, 1'b0);
		end
	endtask

	task automatic t_reduced();
		reduced_build = 1'b1;
		acc(1'b0, 16'h2000, 8'h00, 1'b1);
		check_byte(q, 8'h50, "fitted block word");
		acc(1'b0, 16'hA000, 8'h00, 1'b0);
		acc(1'b1, 16'hFFFF, 8'h33, 1'b0);
		reduced_build = 1'b0;
		acc(1'b0, 16'hFFFF, 8'h00, 1'b1);
		check_byte(q, 8'hC3, "unfitted write left no trace");
	endtask

	// back-to-back reads over two refresh periods must meet a stretched cycle
	task automatic t_refresh();
		worst = 0;
		for (int i = 0; i < 70; i++) begin
			acc(1'b0, 16'h6000, 8'h00, 1'b1);
			check_byte(q, 8'h51, "word during refresh traffic");
			// one negedge before the taken edge, at most one whole refresh added
			check_range(lat, `ACCESS_CYC + 1, `ACCESS_CYC + 1 + `REFRESH_CYC, "ack latency");
			if (lat > worst)
				worst = lat;
		end
		check_range(worst, 25, `ACCESS_CYC + 1 + `REFRESH_CYC, "stretched cycle");
	endtask

	// init in mid-access drops the pending cycle; the held strobe restarts it afresh
	task automatic t_init();
		fork
			acc(1'b0, 16'h6000, 8'h00, 1'b1);
			begin
				repeat (8) @(negedge clock);
				reset_n = 1'b0;
				// long enough that an unflushed access would have acked inside it
				repeat (12) @(negedge clock);
				check_byte({6'h00, ack_n, oe}, 8'h02, "init ack and drive");
				reset_n = 1'b1;
			end
		join
		check_byte(q, 8'h51, "word after init");
		// strobe set one negedge in, init over 20 negedges in, 19 after the strobe, then a full access
		check_range(lat, 19 + `ACCESS_CYC + 1, 19 + `ACCESS_CYC + 1, "restart after init");
	endtask

	initial begin
		repeat (3) @(negedge clock);
		t_reset();
		@(negedge clock);
		reset_n = 1'b1;
		t_map();
		t_reduced();
		t_refresh();
		t_init();
		end_of_test();
	end
endmodule
